// *** vfd_pkg.sv ***
// Constants, types and command decoding for the display command decoder.
// Assumes a 20 MHz system clock; all busy figures are derived from it.
`default_nettype none
package vfd_pkg;
  // Clock rate and busy times in microseconds.
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned T_STD_US = 40;
  localparam int unsigned T_CTRL_US = 50;
  localparam int unsigned T_LONG_US = 150;
  localparam int unsigned T_HOME_US = 500;
  localparam int unsigned T_GDATA_US = 250;
  localparam int unsigned T_AREA_US = 500;
  localparam int unsigned T_CUR_US = 20;
  localparam int unsigned T_SHIFT_US = 150;
  localparam int unsigned CYC_STD = T_STD_US * CLK_MHZ;
  localparam int unsigned CYC_CTRL = T_CTRL_US * CLK_MHZ;
  localparam int unsigned CYC_LONG = T_LONG_US * CLK_MHZ;
  localparam int unsigned CYC_HOME = T_HOME_US * CLK_MHZ;
  localparam int unsigned CYC_GDATA = T_GDATA_US * CLK_MHZ;
  localparam int unsigned CYC_AREA = T_AREA_US * CLK_MHZ;
  localparam int unsigned CYC_CUR = T_CUR_US * CLK_MHZ;
  localparam int unsigned CYC_SHIFT = T_SHIFT_US * CLK_MHZ;
  // Command codes and values.
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam logic [7:0] CMD_HOME = 8'h02;
  localparam logic [7:0] CMD_CUR_L = 8'h10;
  localparam logic [7:0] CMD_CUR_R = 8'h14;
  localparam logic [7:0] CMD_DSH_L = 8'h18;
  localparam logic [7:0] CMD_DSH_R = 8'h1C;
  localparam logic [7:0] CMD_BUS4 = 8'h20;
  localparam logic [7:0] CMD_BUS8 = 8'h30;
  localparam logic [7:0] DD1_LO = 8'h80;
  localparam logic [7:0] DD1_HI = 8'hA7;
  localparam logic [7:0] DD2_LO = 8'hC0;
  localparam logic [7:0] DD2_HI = 8'hE7;
  localparam logic [7:0] CMD_TOP = 8'hE8;
  localparam logic [7:0] CMD_BOT = 8'hE9;
  localparam logic [7:0] CMD_GCUR = 8'hF0;
  localparam logic [7:0] CMD_GAREA = 8'hF1;
  localparam logic [7:0] BLANK = 8'h20;
  localparam logic [7:0] UDF_END = 8'h10;
  localparam logic [1:0] BRIGHT_FULL = 2'h0;
  localparam logic [7:0] ACT_INV = 8'h49;
  localparam logic [7:0] ACT_FILL = 8'h46;
  localparam logic [7:0] ACT_CLR = 8'h43;
  localparam logic [7:0] ACT_OSET = 8'h4F;
  localparam logic [7:0] ACT_OCLR = 8'h6F;
  localparam logic [7:0] ACT_HH = 8'h48;
  localparam logic [7:0] ACT_VH = 8'h56;
  localparam logic [7:0] ACT_HV = 8'h68;
  localparam logic [7:0] ACT_VV = 8'h76;
  typedef enum logic [4:0] {OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DCTL, OP_CUR_L,
    OP_CUR_R, OP_DSH_L, OP_DSH_R, OP_BUS4, OP_BUS8, OP_CGA, OP_DDA, OP_TOP, OP_BOT,
    OP_GCUR, OP_GAREA} op_e;
  typedef enum logic [2:0] {RX_CMD, RX_LUM, RX_GCUR, RX_AREA, RX_IMAGE} rx_e;
  typedef struct packed {
    logic [8:0] left;
    logic [4:0] top;
    logic [8:0] right;
    logic [4:0] bottom;
    logic [7:0] action;
  } area_s;
  typedef struct packed {
    logic [8:0] x;
    logic [4:0] y;
    logic [7:0] data;
    logic [7:0] mask;
    logic vertical;
  } pixel_s;
  // Classifies a command byte; anything outside the defined codes is OP_NONE.
  function automatic op_e decode(input logic [7:0] c);
    op_e r;
    r = OP_NONE;
    if (c == CMD_CLEAR) r = OP_CLEAR;
    else if (c == CMD_HOME) r = OP_HOME;
    else if (c[7:2] == 6'h01) r = OP_ENTRY;
    else if (c[7:3] == 5'h01) r = OP_DCTL;
    else if (c == CMD_CUR_L) r = OP_CUR_L;
    else if (c == CMD_CUR_R) r = OP_CUR_R;
    else if (c == CMD_DSH_L) r = OP_DSH_L;
    else if (c == CMD_DSH_R) r = OP_DSH_R;
    else if (c == CMD_BUS4) r = OP_BUS4;
    else if (c == CMD_BUS8) r = OP_BUS8;
    else if (c[7:6] == 2'h1) r = OP_CGA;
    else if ((c >= DD1_LO && c <= DD1_HI) || (c >= DD2_LO && c <= DD2_HI)) r = OP_DDA;
    else if (c == CMD_TOP) r = OP_TOP;
    else if (c == CMD_BOT) r = OP_BOT;
    else if (c == CMD_GCUR) r = OP_GCUR;
    else if (c == CMD_GAREA) r = OP_GAREA;
    return r;
  endfunction
endpackage
`default_nettype wire

// *** vfd_cmd_decoder.sv ***
// Command decoder of a 280x32 dot display with an LCD compatible command set.
// Host pins arrive asynchronously and are synchronised; one 20 MHz clock.
// How it works
// - Select low marks a command byte, select high a data or parameter byte.
// - Busy rises when a byte is taken and falls when the next may come.
// - Reset selects 8-bit bus, blanks display memory, zeroes address, full brightness.
// - Data read returns display memory byte at the address counter, or glyph memory byte at the glyph address.
// - Status read gives busy in bit 7 and cursor position in bits 0-6.
// - Clear blanks display memory, zeroes counter, sets increment, drops shift.
// - Home zeroes counter and shift offset, with the longest command busy period.
// - Entry bit 1 picks counter increment or decrement after data access.
// - Entry bit 0 shifts the display with each data access.
// - Auto shift lengthens the data write busy time.
// - Display control bit 2 turns display on, bit 0 the block cursor.
// - An enabled cursor lengthens command and data busy times outside graphics mode.
// - Cursor left and right move the counter by exactly one.
// - Display shift left or right moves content one place, long busy.
// - Bus width 4 takes bytes as two upper nibble writes, high first.
// - Bus width commands take a brightness byte with select high.
// - Bus width 8 takes one write per byte on all lines.
// - Glyph address commands steer later data writes into glyph memory.
// - Display address codes pick line pair; two codes pick top or bottom area.
// - Extended commands enter graphics mode with its text and cursor limits.
// - Any valid LCD command leaves graphics mode and restores memory writes.
// - Graphic cursor takes x and y bytes as an absolute pixel position.
// - Area command takes four edges and an action letter, with long busy for area actions only.
// - Image letters pick byte and cursor direction; bytes stay inside, masked.
`timescale 1ns/1ns
`default_nettype none
module vfd_cmd_decoder #(
  parameter int unsigned HOME_CYC = vfd_pkg::CYC_HOME,
  parameter int unsigned GDATA_CYC = vfd_pkg::CYC_GDATA,
  parameter int unsigned AREA_CYC = vfd_pkg::CYC_AREA
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Host pins.
  input wire logic enable_i,
  input wire logic register_select_i,
  input wire logic read_not_write_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic busy_o,
  // Display state.
  output logic display_on_o,
  output logic cursor_on_o,
  output logic graphics_mode_o,
  output logic bus_4bit_o,
  output logic [1:0] brightness_o,
  output logic [6:0] addr_counter_o,
  output logic area_bottom_o,
  output logic [6:0] display_offset_o,
  // Graphic engine requests.
  output vfd_pkg::area_s area_o,
  output logic area_go_o,
  output vfd_pkg::pixel_s image_o,
  output logic image_go_o,
  output logic [7:0] text_o,
  output logic text_go_o
);
  logic [10:0] sync1;
  logic [10:0] sync2;
  logic e_d;
  logic nib_seen;
  logic [3:0] nib_hi;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy;
  logic clr_active;
  logic [7:0] clr_idx;
  logic inc;
  logic auto_shift;
  logic cursor_en;
  logic cg_sel;
  logic [5:0] cg_addr;
  vfd_pkg::rx_e rx_state;
  logic [2:0] pcnt;
  logic [8:0] gx;
  logic [4:0] gy;
  logic img_vdata;
  logic img_vmove;
  logic [7:0] dd [0:255];
  logic [7:0] cg [0:63];

  // Two flip-flops on every host pin before any logic looks at it.
  always_ff @(posedge clk_sys_i) begin
    sync1 <= {enable_i, register_select_i, read_not_write_i, data_i};
    sync2 <= sync1;
    e_d <= sync2[10];
  end

  wire logic rs_s = sync2[9];
  wire logic rw_s = sync2[8];
  wire logic [7:0] d_s = sync2[7:0];
  wire logic wr_edge = e_d & ~sync2[10] & ~rw_s;
  wire logic rd_edge = ~e_d & sync2[10] & rw_s;
  wire logic byte_ok = wr_edge & (~bus_4bit_o | nib_seen);
  wire logic [7:0] byte_val = bus_4bit_o ? {nib_hi, d_s[7:4]} : d_s;
  // Writes during busy are dropped; the host is expected to poll first.
  wire logic accept = byte_ok & ~busy_o;
  wire logic cmd_go = accept & ~rs_s;
  wire logic par_go = accept & rs_s & (rx_state != vfd_pkg::RX_CMD);
  wire logic dat_go = accept & rs_s & (rx_state == vfd_pkg::RX_CMD);
  wire vfd_pkg::op_e op = vfd_pkg::decode(byte_val);
  wire logic lcd_op = op != vfd_pkg::OP_NONE && op != vfd_pkg::OP_GCUR
    && op != vfd_pkg::OP_GAREA;
  wire logic area_act = byte_val inside {vfd_pkg::ACT_INV, vfd_pkg::ACT_FILL,
    vfd_pkg::ACT_CLR, vfd_pkg::ACT_OSET, vfd_pkg::ACT_OCLR};
  wire logic img_act = byte_val inside {vfd_pkg::ACT_HH, vfd_pkg::ACT_VH,
    vfd_pkg::ACT_HV, vfd_pkg::ACT_VV};
  wire logic [3:0] step_x = img_vdata ? 4'h1 : 4'h8;
  wire logic [3:0] step_y = img_vdata ? 4'h8 : 4'h1;
  wire logic [9:0] nx = {1'b0, gx} + {6'h00, step_x};
  wire logic [5:0] ny = {1'b0, gy} + {2'h0, step_y};

  function automatic logic [6:0] step(input logic [6:0] a, input logic up);
    return up ? 7'(a + 7'h01) : 7'(a - 7'h01);
  endfunction

  // Keeps only the pixels that still lie inside the area edge.
  function automatic logic [7:0] edge_mask(input logic [9:0] rem);
    return (rem >= 10'h008) ? 8'hFF : 8'(8'hFF << (4'h8 - rem[3:0]));
  endfunction

  // In 4-bit mode the high nibble is held until the low one arrives.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !bus_4bit_o) begin
      nib_seen <= 1'b0;
      nib_hi <= 4'h0;
    end else if (wr_edge) begin
      nib_seen <= ~nib_seen;
      if (!nib_seen) nib_hi <= d_s[7:4];
    end
  end

  // Busy length of the byte being taken, with cursor and shift extras.
  always_comb begin
    next_busy = 16'(vfd_pkg::CYC_STD);
    if (cmd_go) begin
      unique case (op)
        vfd_pkg::OP_CLEAR, vfd_pkg::OP_DSH_L, vfd_pkg::OP_DSH_R:
          next_busy = 16'(vfd_pkg::CYC_LONG);
        vfd_pkg::OP_HOME: next_busy = 16'(HOME_CYC);
        vfd_pkg::OP_DCTL: next_busy = 16'(vfd_pkg::CYC_CTRL);
        default: next_busy = 16'(vfd_pkg::CYC_STD);
      endcase
    end else if (par_go && rx_state == vfd_pkg::RX_AREA && pcnt == 3'h4 && area_act) begin
      next_busy = 16'(vfd_pkg::CYC_STD + AREA_CYC);
    end else if (dat_go && graphics_mode_o) begin
      next_busy = 16'(GDATA_CYC);
    end else if (dat_go && auto_shift) begin
      next_busy = 16'(vfd_pkg::CYC_STD + vfd_pkg::CYC_SHIFT);
    end
    if (cursor_en && !graphics_mode_o && (cmd_go || dat_go))
      next_busy = 16'(next_busy + 16'(vfd_pkg::CYC_CUR));
  end

  // Busy counter; reset starts busy for the blanking pass.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_o <= 1'b1;
      busy_cnt <= 16'(vfd_pkg::CYC_LONG - 1);
    end else if (accept) begin
      busy_o <= 1'b1;
      busy_cnt <= 16'(next_busy - 16'h0001);
    end else if (busy_cnt != 16'h0000) begin
      busy_cnt <= 16'(busy_cnt - 16'h0001);
    end else begin
      busy_o <= 1'b0;
    end
  end

  // Blanking pass, one location a cycle, well inside the clear busy time.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      clr_active <= 1'b1;
      clr_idx <= 8'h00;
    end else if (cmd_go && op == vfd_pkg::OP_CLEAR) begin
      clr_active <= 1'b1;
      clr_idx <= 8'h00;
    end else if (clr_active) begin
      clr_idx <= 8'(clr_idx + 8'h01);
      if (clr_idx == 8'hFF) clr_active <= 1'b0;
    end
  end

  // Memory writes; graphics mode keeps text out of both memories.
  always_ff @(posedge clk_sys_i) begin
    if (clr_active) dd[clr_idx] <= vfd_pkg::BLANK;
    else if (dat_go && !graphics_mode_o && !cg_sel)
      dd[{area_bottom_o, addr_counter_o}] <= byte_val;
    if (dat_go && !graphics_mode_o && cg_sel) cg[cg_addr] <= byte_val;
  end

  // Read port: status or memory byte, driven while the host reads.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
    end else begin
      data_oe_n_o <= ~(sync2[10] & rw_s);
      if (rd_edge && !rs_s) data_o <= {busy_o, addr_counter_o};
      else if (rd_edge)
        data_o <= cg_sel ? cg[cg_addr] : dd[{area_bottom_o, addr_counter_o}];
    end
  end

  // The cursor shows only outside graphics mode.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) cursor_on_o <= 1'b0;
    else cursor_on_o <= cursor_en & ~graphics_mode_o;
  end

  // Command, parameter and data execution.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_state <= vfd_pkg::RX_CMD;
      pcnt <= 3'h0;
      addr_counter_o <= 7'h00;
      bus_4bit_o <= 1'b0;
      brightness_o <= vfd_pkg::BRIGHT_FULL;
      inc <= 1'b1;
      auto_shift <= 1'b0;
      display_on_o <= 1'b1;
      cursor_en <= 1'b0;
      graphics_mode_o <= 1'b0;
      display_offset_o <= 7'h00;
      cg_sel <= 1'b0;
      cg_addr <= 6'h00;
      area_bottom_o <= 1'b0;
      gx <= 9'h000;
      gy <= 5'h00;
      img_vdata <= 1'b0;
      img_vmove <= 1'b0;
      area_o <= '0;
      image_o <= '0;
      text_o <= 8'h00;
      area_go_o <= 1'b0;
      image_go_o <= 1'b0;
      text_go_o <= 1'b0;
    end else begin
      area_go_o <= 1'b0;
      image_go_o <= 1'b0;
      text_go_o <= 1'b0;
      if (cmd_go && op != vfd_pkg::OP_NONE) begin
        rx_state <= vfd_pkg::RX_CMD;
        pcnt <= 3'h0;
        if (lcd_op) graphics_mode_o <= 1'b0;
        unique case (op)
          vfd_pkg::OP_CLEAR: begin
            addr_counter_o <= 7'h00;
            inc <= 1'b1;
            display_offset_o <= 7'h00;
            cg_sel <= 1'b0;
          end
          vfd_pkg::OP_HOME: begin
            addr_counter_o <= 7'h00;
            display_offset_o <= 7'h00;
            cg_sel <= 1'b0;
          end
          vfd_pkg::OP_ENTRY: begin
            inc <= byte_val[1];
            auto_shift <= byte_val[0];
          end
          vfd_pkg::OP_DCTL: begin
            display_on_o <= byte_val[2];
            cursor_en <= byte_val[0];
          end
          vfd_pkg::OP_CUR_L: addr_counter_o <= step(addr_counter_o, 1'b0);
          vfd_pkg::OP_CUR_R: addr_counter_o <= step(addr_counter_o, 1'b1);
          vfd_pkg::OP_DSH_L: display_offset_o <= step(display_offset_o, 1'b1);
          vfd_pkg::OP_DSH_R: display_offset_o <= step(display_offset_o, 1'b0);
          vfd_pkg::OP_BUS4, vfd_pkg::OP_BUS8: begin
            bus_4bit_o <= (op == vfd_pkg::OP_BUS4);
            rx_state <= vfd_pkg::RX_LUM;
          end
          vfd_pkg::OP_CGA: begin
            cg_sel <= 1'b1;
            cg_addr <= byte_val[5:0];
          end
          vfd_pkg::OP_DDA: begin
            cg_sel <= 1'b0;
            addr_counter_o <= byte_val[6:0];
          end
          vfd_pkg::OP_TOP: area_bottom_o <= 1'b0;
          vfd_pkg::OP_BOT: area_bottom_o <= 1'b1;
          vfd_pkg::OP_GCUR, vfd_pkg::OP_GAREA: begin
            graphics_mode_o <= 1'b1;
            rx_state <= (op == vfd_pkg::OP_GCUR) ? vfd_pkg::RX_GCUR : vfd_pkg::RX_AREA;
          end
          vfd_pkg::OP_NONE: ;
        endcase
      end else if (par_go) begin
        pcnt <= 3'(pcnt + 3'h1);
        unique case (rx_state)
          vfd_pkg::RX_LUM: begin
            brightness_o <= byte_val[1:0];
            rx_state <= vfd_pkg::RX_CMD;
          end
          vfd_pkg::RX_GCUR: begin
            if (pcnt == 3'h0) gx <= {1'b0, byte_val};
            else begin
              gy <= byte_val[4:0];
              rx_state <= vfd_pkg::RX_CMD;
            end
          end
          vfd_pkg::RX_AREA: begin
            unique case (pcnt)
              3'h0: area_o.left <= {1'b0, byte_val};
              3'h1: area_o.top <= byte_val[4:0];
              3'h2: area_o.right <= {1'b0, byte_val};
              3'h3: area_o.bottom <= byte_val[4:0];
              default: begin
                area_o.action <= byte_val;
                area_go_o <= area_act;
                rx_state <= img_act ? vfd_pkg::RX_IMAGE : vfd_pkg::RX_CMD;
                gx <= area_o.left;
                gy <= area_o.top;
                img_vdata <= byte_val == vfd_pkg::ACT_VH || byte_val == vfd_pkg::ACT_VV;
                img_vmove <= byte_val == vfd_pkg::ACT_HV || byte_val == vfd_pkg::ACT_VV;
              end
            endcase
          end
          vfd_pkg::RX_IMAGE: begin
            image_go_o <= 1'b1;
            image_o <= {gx, gy, byte_val, edge_mask(img_vdata
              ? 10'({5'h00, area_o.bottom} - {5'h00, gy} + 10'h001)
              : 10'({1'b0, area_o.right} - {1'b0, gx} + 10'h001)), img_vdata};
            if (!img_vmove && nx > {1'b0, area_o.right}) begin
              gx <= area_o.left;
              gy <= (ny > {1'b0, area_o.bottom}) ? area_o.top : ny[4:0];
            end else if (!img_vmove) begin
              gx <= nx[8:0];
            end else if (ny > {1'b0, area_o.bottom}) begin
              gy <= area_o.top;
              gx <= (nx > {1'b0, area_o.right}) ? area_o.left : nx[8:0];
            end else begin
              gy <= ny[4:0];
            end
          end
          vfd_pkg::RX_CMD: ;
        endcase
      end else if (dat_go && graphics_mode_o) begin
        text_o <= byte_val;
        text_go_o <= byte_val >= vfd_pkg::UDF_END;
      end else if (dat_go || (rd_edge && rs_s && !graphics_mode_o)) begin
        if (cg_sel) cg_addr <= 6'(cg_addr + 6'h01);
        else begin
          addr_counter_o <= step(addr_counter_o, inc);
          if (auto_shift) display_offset_o <= step(display_offset_o, inc);
        end
      end
    end
  end

  // Helpers that measure each busy period against its planned length.
  logic [15:0] busy_run;
  logic [15:0] busy_need;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      busy_run <= 16'h0000;
      busy_need <= 16'(vfd_pkg::CYC_LONG);
    end else if (accept) begin
      busy_run <= 16'h0000; // Counts edges after the load edge, as after reset.
      busy_need <= next_busy;
    end else if (busy_o) busy_run <= 16'(busy_run + 16'h0001);
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_busy_len;
    $fell(busy_o) |-> busy_run == busy_need;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_status;
    rd_edge && !rs_s |=> data_o == {$past(busy_o), $past(addr_counter_o)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_clear;
    cmd_go && op == vfd_pkg::OP_CLEAR |=> addr_counter_o == 7'h00 && inc && clr_active;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_home;
    cmd_go && op == vfd_pkg::OP_HOME |=> addr_counter_o == 7'h00 && display_offset_o == 7'h00;
  endproperty
  a_home: assert property (p_home) else $error("home failed");
  property p_left;
    cmd_go && op == vfd_pkg::OP_CUR_L |=> addr_counter_o == 7'($past(addr_counter_o) - 7'h01);
  endproperty
  a_left: assert property (p_left) else $error("cursor left wrong");
  property p_gfx_in;
    cmd_go && op == vfd_pkg::OP_GCUR |=> graphics_mode_o ##1 !cursor_on_o;
  endproperty
  a_gfx_in: assert property (p_gfx_in) else $error("graphics entry wrong");
  property p_gfx_out;
    cmd_go && lcd_op |=> !graphics_mode_o;
  endproperty
  a_gfx_out: assert property (p_gfx_out) else $error("graphics exit wrong");
  property p_ignore;
    cmd_go && op == vfd_pkg::OP_NONE |=> $stable(addr_counter_o) && $stable(brightness_o)
      && $stable(graphics_mode_o) && $stable(rx_state);
  endproperty
  a_ignore: assert property (p_ignore) else $error("unknown code acted");
  c_clear: cover property (cmd_go && op == vfd_pkg::OP_CLEAR);
  c_area: cover property (area_go_o);
  c_image: cover property (image_go_o);
  c_nibble: cover property (bus_4bit_o && dat_go);
endmodule // vfd_cmd_decoder
`default_nettype wire

// *** host_model.sv ***
// Host side model: drives the parallel E, select, direction and data pins.
// Assumes the bench clock; pins change 1 ns after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock.
  input wire logic clk_i,
  // Host pins.
  output logic enable_o,
  output logic rs_o,
  output logic rnw_o,
  output logic [7:0] data_o
);
  // Idle pins at time zero.
  initial begin
    enable_o = 1'b0;
    rs_o = 1'b0;
    rnw_o = 1'b1;
    data_o = 8'h00;
  end
  // One E pulse; select and direction settle before E rises and hold past its fall.
  // Afterwards the data lines show the inverse, since a stale value could hide a late take.
  task automatic cycle(input logic rs, input logic rnw, input logic [7:0] d);
    @(posedge clk_i) #1;
    rs_o = rs;
    rnw_o = rnw;
    data_o = d;
    @(posedge clk_i) #1;
    enable_o = 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    enable_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    data_o = ~d;
    rnw_o = 1'b1;
  endtask
endmodule // host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the display command decoder, driven by the host model.
// Assumes the 20 MHz clock and short busy parameters for home, graphics data and area.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en, rs, rnw, oe_n, busy, dispon, curon, gmode, bus4, abot;
  logic [7:0] din, dout;
  logic [1:0] bright;
  logic [6:0] addr, offs;
  logic ago, igo, tgo;
  logic [7:0] txt;
  vfd_pkg::area_s area;
  vfd_pkg::pixel_s image;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  int n_oe = 0, n_area = 0, n_img = 0, n_txt = 0;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  // Pulses and the read drive window are counted on the falling edge, where they are settled.
  always @(negedge clk) begin
    if (oe_n === 1'b0) n_oe++;
    if (ago === 1'b1) n_area++;
    if (igo === 1'b1) n_img++;
    if (tgo === 1'b1) n_txt++;
  end
  host_model host_model_inst (.clk_i(clk), .enable_o(en), .rs_o(rs), .rnw_o(rnw), .data_o(din));
  vfd_cmd_decoder #(.HOME_CYC(50), .GDATA_CYC(30), .AREA_CYC(40)) vfd_cmd_decoder_inst (
    .clk_sys_i(clk), .sys_rst_i(rst), .enable_i(en), .register_select_i(rs),
    .read_not_write_i(rnw), .data_i(din), .data_o(dout), .data_oe_n_o(oe_n), .busy_o(busy),
    .display_on_o(dispon), .cursor_on_o(curon), .graphics_mode_o(gmode), .bus_4bit_o(bus4),
    .brightness_o(bright), .addr_counter_o(addr), .area_bottom_o(abot),
    .display_offset_o(offs), .area_o(area), .area_go_o(ago), .image_o(image),
    .image_go_o(igo), .text_o(txt), .text_go_o(tgo));
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait for ready; n returns the cycles spent busy.
  task automatic wait_ready();
    for (n = 0; n < 20000 && busy !== 1'b0; n++) @(posedge clk) #1;
    if (n == 20000) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] d);
    wait_ready();
    host_model_inst.cycle(s, 1'b0, d);
  endtask
  // The pins are driven for the six clocks that E stands high, three clocks late: two sync stages and the output flop.
  task automatic rd(input logic s);
    int k;
    wait_ready();
    k = n_oe;
    host_model_inst.cycle(s, 1'b1, 8'h00);
    chk(16'(n_oe - k), 6);
  endtask
  task automatic t_basic();
    chk(bus4, 0);
    chk(bright, 0);
    chk(dispon, 1);
    rd(0);
    chk(dout, 8'h00);
    wr(1, 8'h41);
    chk(addr, 1);
    wr(0, 8'h80);
    rd(1);
    chk(dout, 8'h41);
    wr(0, vfd_pkg::CMD_CLEAR);
    chk(addr, 0);
    rd(1);
    chk(dout, vfd_pkg::BLANK);
    $display("test basic done");
  endtask
  task automatic t_move();
    wr(0, 8'h04);
    wr(0, 8'h85);
    wr(1, 8'h42);
    chk(addr, 4);
    wr(0, vfd_pkg::CMD_CUR_R);
    chk(addr, 5);
    wr(0, vfd_pkg::CMD_CUR_L);
    wr(0, vfd_pkg::CMD_CUR_L);
    chk(addr, 3);
    wr(0, vfd_pkg::CMD_DSH_R);
    chk(offs, 7'h7F);
    wr(0, 8'h07);
    wr(1, 8'h43);
    chk(offs, 0);
    wait_ready();
    chk(16'(n >= 3780 && n <= 3800), 1);
    wr(0, vfd_pkg::CMD_HOME);
    chk(addr, 0);
    chk(offs, 0);
    $display("test move done");
  endtask
  task automatic t_busy();
    wr(0, 8'h06);
    wr(0, vfd_pkg::CMD_CUR_R);
    wait_ready();
    chk(16'(n >= 780 && n <= 800), 1);
    wr(0, 8'h0D);
    wr(0, vfd_pkg::CMD_CUR_R);
    wait_ready();
    chk(16'(n >= 1180 && n <= 1200), 1);
    $display("test busy done");
  endtask
  // Bus width: the 8-bit command itself arrives as two nibbles, high first.
  task automatic t_bus();
    wr(0, vfd_pkg::CMD_BUS4);
    wr(1, 8'h00);
    wr(1, 8'h20);
    chk(bus4, 1);
    chk(bright, 2);
    repeat (900) @(posedge clk);
    host_model_inst.cycle(0, 0, 8'h30);
    host_model_inst.cycle(0, 0, 8'h00);
    wr(1, 8'h01);
    chk(bus4, 0);
    chk(bright, 1);
    $display("test bus done");
  endtask
  task automatic t_gfx();
    wr(0, vfd_pkg::CMD_GCUR);
    wr(1, 8'h0A);
    wr(1, 8'h05);
    chk(gmode, 1);
    chk(curon, 0);
    wr(0, 8'h0D);
    chk(gmode, 0);
    chk(curon, 1);
    wr(0, 8'h03);
    chk({addr, gmode, bright}, {7'h02, 1'b0, 2'h1});
    $display("test gfx done");
  endtask
  // Extended commands: area fill, a masked image, graphics text, glyph and area addressing.
  task automatic t_ext();
    wr(0, 8'h0C);
    chk(curon, 0);
    wr(0, vfd_pkg::CMD_GAREA);
    wr(1, 8'h04);
    wr(1, 8'h02);
    wr(1, 8'h0B);
    wr(1, 8'h03);
    wr(1, vfd_pkg::ACT_FILL);
    wait_ready();
    chk(16'(n >= 820 && n <= 840), 1);
    chk({area.left[7:0], area.action}, {8'h04, vfd_pkg::ACT_FILL});
    chk({3'h0, area.top, 3'h0, area.bottom}, 16'h0203);
    chk(16'(n_area), 1);
    wr(0, vfd_pkg::CMD_GAREA);
    wr(1, 8'h00);
    wr(1, 8'h00);
    wr(1, 8'h09);
    wr(1, 8'h07);
    wr(1, vfd_pkg::ACT_HH);
    wr(1, 8'hA5);
    chk({image.data, image.mask}, 16'hA5FF);
    wr(1, 8'h3C);
    chk({image.data, image.mask}, 16'h3CC0);
    chk({image.x[7:0], 3'h0, image.y}, 16'h0800);
    chk(16'(n_img), 2);
    wr(0, vfd_pkg::CMD_GCUR);
    wr(1, 8'h14);
    wr(1, 8'h09);
    wr(1, 8'h41);
    chk(txt, 8'h41);
    wr(1, 8'h05);
    chk(16'(n_txt), 1);
    chk(addr, 7'h02);
    wr(0, 8'h40);
    chk(gmode, 0);
    wr(1, 8'h1F);
    wr(0, 8'h40);
    rd(1);
    chk(dout, 8'h1F);
    wr(0, vfd_pkg::CMD_BOT);
    chk(abot, 1);
    wr(0, 8'hC0);
    chk(addr, 7'h40);
    wr(0, vfd_pkg::CMD_TOP);
    chk(abot, 0);
    wr(0, 8'h08);
    chk(dispon, 0);
    $display("test ext done");
  endtask
  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_basic();
    t_move();
    t_busy();
    t_bus();
    t_gfx();
    t_ext();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
